// File: rtl/icu_map.svh
// Integer compare unit: opcode and field positions as macros.
// Assumes inclusion by bare name from rtl/ sources.
`ifndef ICU_MAP_SVH
`define ICU_MAP_SVH
`define ICU_OP_RTYPE     6'h3a
`define ICU_OP_GEI       6'h08
`define ICU_OP_LTI       6'h10
`define ICU_OP_NEI       6'h18
`define ICU_OP_GEUI      6'h28
`define ICU_OP_LTUI      6'h30
`define ICU_OPX_GE       6'h08
`define ICU_OPX_LT       6'h10
`define ICU_OPX_NE       6'h18
`define ICU_OPX_GEU      6'h28
`define ICU_OPX_LTU      6'h30
`define ICU_SRC1_HI      31
`define ICU_SRC1_LO      27
`define ICU_SRC2_HI      26
`define ICU_SRC2_LO      22
`define ICU_DST_HI       21
`define ICU_DST_LO       17
`define ICU_OPX_HI       16
`define ICU_OPX_LO       11
`define ICU_IMM_HI       21
`define ICU_IMM_LO       6
`define ICU_OP_HI        5
`define ICU_OP_LO        0
`endif

// File: rtl/icu_pkg.sv
// Integer compare unit: shared types.
// Assumes nothing beyond the header of constants.
package icu_pkg;
  typedef enum logic [5:0] {
    ICU_CMP_LT  = 6'h01,
    ICU_CMP_LTU = 6'h02,
    ICU_CMP_NE  = 6'h04,
    ICU_CMP_GE  = 6'h08,
    ICU_CMP_GEU = 6'h10,
    ICU_CMP_NONE = 6'h20
  } icu_cmp_e;
endpackage

// File: rtl/icu_decode.sv
// Integer compare unit: instruction decoder.
// Assumes a 32-bit instruction word valid in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "icu_map.svh"
module icu_decode
  import icu_pkg::*;
(
  input  wire logic [31:0] instr_in,     // Instruction word
  output var icu_cmp_e     cmp_out,      // Selected compare
  output logic             use_imm_out,  // Immediate form
  output logic             sext_out,     // Sign-extend immediate
  output logic [4:0]       src_idx_out,  // first_source_reg index
  output logic [4:0]       src2_idx_out, // second_reg index
  output logic [4:0]       dst_idx_out,  // Destination index
  output logic [15:0]      imm_out       // imm_field
);
  logic [5:0] op;
  logic [5:0] opx;
  // Field extraction
  // field positions
  assign op           = instr_in[`ICU_OP_HI:`ICU_OP_LO];
  assign opx          = instr_in[`ICU_OPX_HI:`ICU_OPX_LO];
  assign src_idx_out  = instr_in[`ICU_SRC1_HI:`ICU_SRC1_LO];
  assign src2_idx_out = instr_in[`ICU_SRC2_HI:`ICU_SRC2_LO];
  assign imm_out      = instr_in[`ICU_IMM_HI:`ICU_IMM_LO];
  // Opcode decode
  always_comb begin
    cmp_out     = ICU_CMP_NONE;
    use_imm_out = 1'b0;
    sext_out    = 1'b0;
    dst_idx_out = instr_in[`ICU_DST_HI:`ICU_DST_LO];
    if (op == `ICU_OP_RTYPE) begin
      case (opx)
        `ICU_OPX_LT:  cmp_out = ICU_CMP_LT;
        `ICU_OPX_LTU: cmp_out = ICU_CMP_LTU;
        `ICU_OPX_NE:  cmp_out = ICU_CMP_NE;
        `ICU_OPX_GE:  cmp_out = ICU_CMP_GE;
        `ICU_OPX_GEU: cmp_out = ICU_CMP_GEU;
        default:      cmp_out = ICU_CMP_NONE;
      endcase
    end else begin
      use_imm_out = 1'b1;
      dst_idx_out = instr_in[`ICU_SRC2_HI:`ICU_SRC2_LO];
      case (op)
        `ICU_OP_LTI:  begin cmp_out = ICU_CMP_LT;  sext_out = 1'b1; end
        `ICU_OP_LTUI: cmp_out = ICU_CMP_LTU;
        `ICU_OP_NEI:  begin cmp_out = ICU_CMP_NE;  sext_out = 1'b1; end
        `ICU_OP_GEI:  begin cmp_out = ICU_CMP_GE;  sext_out = 1'b1; end
        `ICU_OP_GEUI: cmp_out = ICU_CMP_GEU;
        default:      cmp_out = ICU_CMP_NONE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: rtl/icu_top.sv
// Integer compare unit: decode, operand fetch request, compare, writeback.
// Assumes a register file with combinational reads and a one-cycle write.
// Assumes the producer builds the derived compare forms itself.
`timescale 1ns/1ps
`default_nettype none
`include "icu_map.svh"
module icu_top
  import icu_pkg::*;
#(
  parameter int DATA_W = 32  // Register word width, wider than the immediate
)
(
  input  wire logic              core_clk_in,   // Core clock
  input  wire logic              rstn_in,       // Async reset, active low
  input  wire logic              valid_in,      // Instruction valid
  input  wire logic [31:0]       instr_in,      // Instruction word
  input  wire logic [DATA_W-1:0] src_data_in,   // first_source_reg value
  input  wire logic [DATA_W-1:0] src2_data_in,  // second_reg value
  output logic [4:0]             src_idx_out,   // first_source_reg read index
  output logic [4:0]             src2_idx_out,  // second_reg read index
  output logic                   accept_out,    // Instruction is a compare
  output logic                   wr_en_out,     // Register write strobe
  output logic [4:0]             wr_idx_out,    // Register write index
  output logic [DATA_W-1:0]      wr_data_out    // Register write data
);

  // Immediate width, fixed by the instruction format
  localparam int IMM_W = `ICU_IMM_HI - `ICU_IMM_LO + 1;
  // Register index width, fixed by the instruction format
  localparam int IDX_W = `ICU_DST_HI - `ICU_DST_LO + 1;

  // Registered write port; index and data hold between writes
  typedef struct packed {
    logic              wr_en;    // One-cycle write strobe
    logic [IDX_W-1:0]  wr_idx;   // Destination index
    logic [DATA_W-1:0] wr_data;  // Result word, zero or one
  } icu_state_s;

  // Write-port state
  icu_state_s        st_q;         // Registered state
  icu_state_s        st_d;         // Next state

  // Reset release
  logic [1:0]        rst_sync_q;   // Release stages
  logic              rstn;         // Re-timed reset, active low

  // Decoder results
  icu_cmp_e          cmp;          // Selected compare kind
  logic              use_imm;      // Immediate form
  logic              sext;         // Sign-extend the immediate
  logic [IDX_W-1:0]  dst_idx;      // Destination index
  logic [IMM_W-1:0]  imm;          // imm_field
  logic              is_cmp;       // Word decodes as a compare

  // Compare datapath
  logic [DATA_W-1:0] opnd_b;       // Second compare operand
  logic              lt_signed;    // First below second, signed
  logic              lt_unsigned;  // First below second, unsigned
  logic              differs;      // Some bit differs
  logic              res;          // Selected result bit

  // Signed less-than on two words
  function automatic logic icu_slt(
    input logic [DATA_W-1:0] a,  // Left operand
    input logic [DATA_W-1:0] b   // Right operand
  );
    icu_slt = $signed(a) < $signed(b);
  endfunction

  // Unsigned less-than on two words
  function automatic logic icu_ult(
    input logic [DATA_W-1:0] a,  // Left operand
    input logic [DATA_W-1:0] b   // Right operand
  );
    icu_ult = a < b;
  endfunction

  // Widen the immediate field, by its sign bit or by zeros
  function automatic logic [DATA_W-1:0] icu_widen(
    input logic [IMM_W-1:0] k,           // Immediate field
    input logic             signed_form  // Copy the sign bit upward
  );
    if (signed_form) begin
      icu_widen = {{(DATA_W-IMM_W){k[IMM_W-1]}}, k};
    end else begin
      icu_widen = {{(DATA_W-IMM_W){1'b0}}, k};
    end
  endfunction

  // Result bit as a full register word, upper bits clear
  function automatic logic [DATA_W-1:0] icu_flag_word(
    input logic flag  // Compare outcome
  );
    icu_flag_word = {{(DATA_W-1){1'b0}}, flag};
  endfunction

  // Reset release through two flops; asserting stays asynchronous,
  // releasing lands on a clock edge so no flop leaves reset early
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rstn = rst_sync_q[1];

  // Field extraction and opcode decode
  icu_decode u_dec (
    .instr_in     (instr_in),
    .cmp_out      (cmp),
    .use_imm_out  (use_imm),
    .sext_out     (sext),
    .src_idx_out  (src_idx_out),
    .src2_idx_out (src2_idx_out),
    .dst_idx_out  (dst_idx),
    .imm_out      (imm)
  );

  // Second operand: widened immediate or second register value
  always_comb begin
    if (use_imm) begin
      opnd_b = icu_widen(imm, sext);
    end else begin
      // Register forms compare the two source registers
      opnd_b = src2_data_in;
    end
  end

  // Three primitive relations; each compare kind picks one,
  // the greater-or-equal kinds by inverting a less-than
  assign lt_signed   = icu_slt(src_data_in, opnd_b);
  assign lt_unsigned = icu_ult(src_data_in, opnd_b);
  assign differs     = src_data_in != opnd_b;

  // Compare evaluation
  always_comb begin
    unique case (cmp)
      ICU_CMP_LT:   res = lt_signed;
      ICU_CMP_LTU:  res = lt_unsigned;
      ICU_CMP_NE:   res = differs;
      ICU_CMP_GE:   res = !lt_signed;
      ICU_CMP_GEU:  res = !lt_unsigned;
      // Not a compare: result unused
      ICU_CMP_NONE: res = 1'b0;
      default:      res = 1'b0;
    endcase
  end

  // Derived forms are the producer's job; the unit has no codes for them:
  //   unsigned greater, registers   -> unsigned less-than, sources swapped
  //   signed less-or-equal          -> signed greater-or-equal, sources swapped
  //   unsigned less-or-equal        -> unsigned greater-or-equal, sources swapped
  //   unsigned greater, constant    -> unsigned greater-or-equal immediate, plus one
  //   unsigned less-or-equal, const -> unsigned less-than immediate, plus one
  //   signed less-or-equal, const   -> signed less-than immediate, plus one
  // The constant is not range-checked here: one that overflows the
  // immediate field after the increment wraps and gives a wrong answer.
  // Both greater-or-equal kinds must therefore exist natively,
  // in register and in immediate form.

  // A word is taken only while valid and decoded as a compare;
  // refused words drop the strobe and leave write index and data untouched
  assign is_cmp     = (cmp != ICU_CMP_NONE);
  assign accept_out = valid_in && is_cmp;

  // Next state: one write per accepted compare
  // Index and data hold between writes; only the strobe falls
  always_comb begin
    st_d       = st_q;
    st_d.wr_en = accept_out;
    if (accept_out) begin
      st_d.wr_idx  = dst_idx;
      st_d.wr_data = icu_flag_word(res);
    end
  end

  // State register; all zero until two edges after reset release,
  // so requests made earlier than that are lost
  always_ff @(posedge core_clk_in or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Write port straight from flops;
  // a result appears at the same edge that takes its word
  assign wr_en_out   = st_q.wr_en;
  assign wr_idx_out  = st_q.wr_idx;
  assign wr_data_out = st_q.wr_data;
endmodule
`default_nettype wire

// File: verification/icu_cmp_monitor.sv
// Checker on compare unit ports.
// Bound into icu_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module icu_cmp_monitor (
  input wire logic        core_clk_in,  // Clock
  input wire logic        rstn_in,      // Reset
  input wire logic [31:0] instr_in,     // Word
  input wire logic [31:0] src_data_in,  // First
  input wire logic [31:0] src2_data_in, // Second
  input wire logic        accept_out,   // Taken
  input wire logic        wr_en_out,    // Write
  input wire logic [31:0] wr_data_out   // Result
);
  // Kind code and reference compares
  wire logic        rt = instr_in[5:0] == 6'h3a;
  wire logic [5:0]  x  = rt ? instr_in[16:11] : instr_in[5:0];
  wire logic [31:0] s  = rt ? src2_data_in : {{16{instr_in[21]}}, instr_in[21:6]};
  wire logic [31:0] u  = rt ? src2_data_in : {16'h0, instr_in[21:6]};
  wire logic        lt = $signed(src_data_in) < $signed(s);
  wire logic        lu = src_data_in < u;
  wire logic        ne = src_data_in != s;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  write_pulse_a: assert property (accept_out |=> wr_en_out)
    else $error("no write");
  no_write_a: assert property (!accept_out |=> !wr_en_out)
    else $error("bad write");
  upper_zero_a: assert property (wr_en_out |-> wr_data_out[31:1] == 31'h0)
    else $error("upper bits");
  signed_lt_a: assert property (accept_out && x == 6'h10 |=> wr_data_out[0] == $past(lt))
    else $error("lt");
  unsigned_lt_a: assert property (accept_out && x == 6'h30 |=> wr_data_out[0] == $past(lu))
    else $error("ltu");
  not_equal_a: assert property (accept_out && x == 6'h18 |=> wr_data_out[0] == $past(ne))
    else $error("ne");
  signed_ge_a: assert property (accept_out && x == 6'h08 |=> wr_data_out[0] != $past(lt))
    else $error("ge");
  unsigned_ge_a: assert property (accept_out && x == 6'h28 |=> wr_data_out[0] != $past(lu))
    else $error("geu");
endmodule
bind icu_top icu_cmp_monitor mon (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .instr_in(instr_in),
  .src_data_in(src_data_in), .src2_data_in(src2_data_in), .accept_out(accept_out),
  .wr_en_out(wr_en_out), .wr_data_out(wr_data_out));
`default_nettype wire

// File: verification/icu_regfile_model.sv
// Register file model with combinational reads.
// Contents are loaded by the bench at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module icu_regfile_model (
  input wire logic [4:0] a_idx_in, // First index
  input wire logic [4:0] b_idx_in, // Second index
  output logic [31:0]    a_out,    // First data
  output logic [31:0]    b_out     // Second data
);
  logic [31:0] regs_q [32];
  // Known contents from time zero
  initial foreach (regs_q[i]) regs_q[i] = 32'h0;
  // Read ports
  assign a_out = regs_q[a_idx_in];
  assign b_out = regs_q[b_idx_in];
endmodule
`default_nettype wire

// File: verification/integer_compare_unit_tb.sv
// Bench for the compare unit and a register file model.
// Inputs change at the falling edge; each write is checked.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module integer_compare_unit_tb;
  logic        core_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        valid_in = 1'b0;
  logic [31:0] instr_in = 32'h0;
  logic [31:0] sa, sb, wr_data;
  logic [4:0]  ia, ib, wr_idx;
  logic        accept, wr_en;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cyc = 0;
  icu_top uut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .valid_in(valid_in), .instr_in(instr_in),
    .src_data_in(sa), .src2_data_in(sb), .src_idx_out(ia), .src2_idx_out(ib), .accept_out(accept),
    .wr_en_out(wr_en), .wr_idx_out(wr_idx), .wr_data_out(wr_data));
  icu_regfile_model rf (.a_idx_in(ia), .b_idx_in(ib), .a_out(sa), .b_out(sb));
  // Clock and hang guard
  initial forever #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 500) begin
      miscompares++;
      report_and_stop;
    end
  end
  function automatic logic [31:0] rr(input logic [5:0] x);
    return {5'h01, 5'h02, 5'h03, x, 5'h00, 6'h3a};
  endfunction
  function automatic logic [31:0] im(input logic [5:0] o, input logic [15:0] k);
    return {5'h01, 5'h04, k, o};
  endfunction
  // Load operands, issue one compare, check its write
  task automatic op(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b, input logic r);
    rf.regs_q[1] = a;
    rf.regs_q[2] = b;
    instr_in = w;
    valid_in = 1'b1;
    #1;
    `CHK(accept, 1'b1)
    @(negedge core_clk_in);
    `CHK(wr_en, 1'b1)
    `CHK(wr_idx, (w[5:0] == 6'h3a) ? w[21:17] : w[26:22])
    `CHK(wr_data, {31'h0, r})
  endtask
  task automatic t_reg;
    op(rr(6'h10), 32'h80000000, 32'h1, 1'b1);
    op(rr(6'h30), 32'h80000000, 32'h1, 1'b0);
    op(rr(6'h18), 32'h5a5a5a5a, 32'h5a5a5a5a, 1'b0);
    op(rr(6'h18), 32'h5a5a5a5a, 32'hda5a5a5a, 1'b1);
    op(rr(6'h08), 32'h1, 32'h80000000, 1'b1);
    op(rr(6'h28), 32'h1, 32'h80000000, 1'b0);
  endtask
  task automatic t_imm;
    op(im(6'h10, 16'hffff), 32'hfffffffe, 32'h0, 1'b1);
    op(im(6'h10, 16'hffff), 32'h00000005, 32'h0, 1'b0);
    op(im(6'h30, 16'hffff), 32'hfffffffe, 32'h0, 1'b0);
    op(im(6'h18, 16'hffff), 32'hffffffff, 32'h0, 1'b0);
    op(im(6'h08, 16'h8000), 32'hffff8000, 32'h0, 1'b1);
    op(im(6'h28, 16'h8000), 32'h00007fff, 32'h0, 1'b0);
  endtask
  // Derived forms issued as the producer must
  task automatic t_pseudo;
    op(rr(6'h30), 32'h3, 32'h5, 1'b1); // swapped
    op(rr(6'h08), 32'h5, 32'hfffffffb, 1'b1); // swapped
    op(rr(6'h28), 32'h7, 32'h7, 1'b1); // swapped
    op(im(6'h28, 16'hffff), 32'h0000ffff, 32'h0, 1'b1); // plus one
    op(im(6'h30, 16'hffff), 32'h0000fffe, 32'h0, 1'b1); // plus one
    op(im(6'h10, 16'h8000), 32'hffff7fff, 32'h0, 1'b1); // plus one
  endtask
  task automatic t_refuse;
    instr_in = rr(6'h20);
    #1;
    `CHK(accept, 1'b0)
    @(negedge core_clk_in);
    `CHK(wr_en, 1'b0)
    instr_in = im(6'h20, 16'h0);
    #1;
    `CHK(accept, 1'b0)
    @(negedge core_clk_in);
    `CHK(wr_en, 1'b0)
    valid_in = 1'b0;
    instr_in = rr(6'h10);
    #1;
    `CHK(accept, 1'b0)
    @(negedge core_clk_in);
    `CHK(wr_en, 1'b0)
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Reset, then the scenarios back to back
  initial begin
    repeat (12) @(negedge core_clk_in);
    rstn_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    t_reg;
    t_imm;
    t_pseudo;
    t_refuse;
    report_and_stop;
  end
endmodule
`default_nettype wire
